// [test/lsss_host_model.sv]
module lsss_host_model (
  // Clock
  input  wire logic sys_clk,
  // Select and write status seen by the block
  output logic      spi_cs_n,
  output logic      ee_write_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle host: deselected, no write
  initial begin
    spi_cs_n = 1'h1;
    ee_write_busy = 1'h0;
  end

  // No serial clock edges are made, so neither an early edge nor another operation
  task automatic access(input int n);
    @(posedge sys_clk);
    #2 spi_cs_n = 1'h0;
    repeat (n) @(posedge sys_clk);
    #2 spi_cs_n = 1'h1;
  endtask : access

  // Write keeps running after select has been dropped
  task automatic ee_write(input int n);
    ee_write_busy = 1'h1;
    access(4);
    repeat (n) @(posedge sys_clk);
    #2 ee_write_busy = 1'h0;
  endtask : ee_write
endmodule : lsss_host_model

// [test/lsss_selector_tb_top.sv]
module lsss_selector_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 sys_clk = 1'h0;
  logic                 rstn = 1'h0;
  logic                 fok = 1'h0;
  logic                 cs_n;
  logic                 busy;
  lsss_pkg::lsss_pins_t pins;
  lsss_pkg::lsss_sw_t   sw;
  lsss_pkg::lsss_src_t  src;
  logic                 tag_logic_en;
  int                   bad_count = 0;
  int                   tests_run = 0;
  // Expected {field, host, source, tag enable}
  localparam logic [4:0] OFF  = {2'h0, lsss_pkg::LSSS_SRC_OFF, 1'h0};
  localparam logic [4:0] HOST = {2'h1, lsss_pkg::LSSS_SRC_HOST, 1'h0};
  localparam logic [4:0] FLD  = {2'h2, lsss_pkg::LSSS_SRC_FIELD, 1'h1};

  always #10 sys_clk = ~sys_clk;

  // Short hold-off keeps the run brief; waits below are sized from 20
  // Pin bundle as the block sees it
  assign pins = '{field_power_ok: fok, spi_cs_n: cs_n, ee_write_busy: busy};

  lsss_selector #(.HOLD_CYCLES(20)) lsss_selector_i (.sys_clk(sys_clk), .rstn(rstn),
    .pins(pins), .sw(sw), .src(src), .tag_logic_en(tag_logic_en));
  lsss_host_model lsss_host_model_i (.sys_clk(sys_clk), .spi_cs_n(cs_n), .ee_write_busy(busy));

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : cyc

  task automatic chk(input logic [4:0] exp);
    tests_run++;
    if ({sw, src, tag_logic_en} !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, {sw, src, tag_logic_en}, exp);
    end
  endtask : chk

  task automatic stop_test();
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // Field on then off
  task automatic t_field();
    fok = 1'h1;
    cyc(8);
    chk(FLD);
    fok = 1'h0;
    cyc(8);
    chk(OFF);
  endtask : t_field

  // Host select, then hold-off after release
  task automatic t_host();
    fork
      lsss_host_model_i.access(10);
      begin cyc(8); chk(HOST); end
    join
    cyc(20);
    chk(HOST);
    cyc(12);
    chk(OFF);
  endtask : t_host

  // Second select inside the hold-off restarts it
  task automatic t_retrig();
    lsss_host_model_i.access(4);
    cyc(10);
    lsss_host_model_i.access(4);
    cyc(16);
    chk(HOST);
    cyc(16);
    chk(OFF);
  endtask : t_retrig

  // Write outlives select; field arriving mid-select wins
  task automatic t_write_prio();
    fork
      lsss_host_model_i.ee_write(40);
      begin cyc(30); chk(HOST); end
    join
    cyc(30);
    chk(OFF);
    fork
      lsss_host_model_i.access(20);
      begin cyc(6); fok = 1'h1; cyc(8); chk(FLD); end
    join
    fok = 1'h0;
    cyc(40);
    chk(OFF);
  endtask : t_write_prio

  // Busy must keep the host rail through a long write
  task automatic t_write();
    fork
      lsss_host_model_i.ee_write(40);
      begin cyc(35); chk(HOST); end
    join
    cyc(32);
    chk(OFF);
  endtask : t_write

  initial begin
    #50us;
    bad_count++;
    stop_test();
  end

  initial begin
    cyc(4);
    chk(OFF);
    rstn = 1'h1;
    t_field();
    t_host();
    t_retrig();
    t_write();
    t_write_prio();
    stop_test();
  end
endmodule : lsss_selector_tb_top

// [verilog/lsss_pkg.sv]
package lsss_pkg;

  // Supply source selection for the logic node
  typedef enum logic [1:0] {
    LSSS_SRC_OFF,
    LSSS_SRC_FIELD,
    LSSS_SRC_HOST
  } lsss_src_t;

  // Clock rate and release hold-off
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned HOLD_OFF_NS     = 700_000;
  localparam int unsigned HOLD_OFF_CYCLES = (HOLD_OFF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Reset values
  localparam logic [2:0] SYNC_RST   = 3'h0;
  localparam logic       SYNC_CS_RST = 1'h1;

  // Switch control bundle driven to the analog supply switches
  typedef struct packed {
    logic field_sw;
    logic host_sw;
  } lsss_sw_t;

  // Raw pin levels that need synchronising
  typedef struct packed {
    logic field_power_ok;
    logic spi_cs_n;
    logic ee_write_busy;
  } lsss_pins_t;

endpackage : lsss_pkg

// [verilog/lsss_selector.sv]
// Function
// - With no field power, chip select high, no write busy and the hold-off run out, both supply switches open (standby).
// - Once field power is reported good, the logic node is tied to the field rail.
// - The field rail always wins; the host rail is used only when field power is absent.
// - The host rail is connected only while field power is absent and chip select is low, a write is busy or the hold-off runs.
// - After chip select rises the host switch stays closed for at least 0.7 ms.
// - An EEPROM write started over SPI keeps the host switch closed even with chip select high.
// - Front end and tag logic are enabled only when field power is good; hysteresis is analog.
module lsss_selector #(
  parameter int unsigned HOLD_CYCLES = lsss_pkg::HOLD_OFF_CYCLES
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // Asynchronous inputs from detector, SPI pins and EEPROM controller
  input  wire lsss_pkg::lsss_pins_t pins,
  // Supply switch controls
  output lsss_pkg::lsss_sw_t     sw,
  output lsss_pkg::lsss_src_t    src,
  // Enable of front end and tag logic
  output logic                   tag_logic_en
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD_CYCLES);
  localparam int NP = $bits(lsss_pkg::lsss_pins_t);

  // Idle level of each pin: detector low, select high, no write
  localparam lsss_pkg::lsss_pins_t PIN_IDLE = '{
    field_power_ok: lsss_pkg::SYNC_RST[0],
    spi_cs_n:       lsss_pkg::SYNC_CS_RST,
    ee_write_busy:  lsss_pkg::SYNC_RST[0]
  };
  localparam logic [NP-1:0] PIN_IDLE_V = PIN_IDLE;

  wire  logic [NP-1:0]  pin_raw;
  wire  logic [NP-1:0]  pin_flt;
  lsss_pkg::lsss_pins_t flt;
  logic                 fld_ok_r;
  logic                 cs_n_r;
  logic                 eew_r;
  logic [CW-1:0]        hold_r;
  logic [CW-1:0]        rel_cnt_r;
  logic                 host_req;
  lsss_pkg::lsss_src_t  src_nxt;

  // Pins enter as one vector so the synchroniser can be generated per bit
  assign pin_raw = pins;

  // Three stages and an agreement filter per pin; stage one feeds only stage two
  for (genvar gi = 0; gi < NP; gi++) begin : g_pin
    logic [2:0] sync_r;
    logic       flt_r;

    // Chain resets to the idle level so no false edge follows reset
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        sync_r <= {3{PIN_IDLE_V[gi]}};
      end else begin
        sync_r <= {sync_r[1:0], pin_raw[gi]};
      end
    end

    // A level counts only when stages two and three agree, so a one-cycle runt is lost
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        flt_r <= PIN_IDLE_V[gi];
      end else if (sync_r[1] == sync_r[2]) begin
        flt_r <= sync_r[2];
      end
    end

    assign pin_flt[gi] = flt_r;
  end : g_pin

  // Filtered levels, named for the logic below
  assign flt      = pin_flt;
  assign fld_ok_r = flt.field_power_ok;
  assign cs_n_r   = flt.spi_cs_n;
  assign eew_r    = flt.ee_write_busy;

  // Host demand: select low or write busy keep the counter loaded
  assign host_req = !cs_n_r || eew_r;

  // Hold-off counter reloads while demanded, so a fresh select fall restarts it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hold_r <= '0;
    end else if (host_req) begin
      hold_r <= HOLD_LOAD;
    end else if (hold_r != '0) begin
      hold_r <= hold_r - CW'(1);
    end
  end

  // Switch pattern for a source; at most one switch may close at a time
  function automatic lsss_pkg::lsss_sw_t src_to_sw(input lsss_pkg::lsss_src_t s);
    lsss_pkg::lsss_sw_t r;
    unique case (s)
      lsss_pkg::LSSS_SRC_FIELD: r = '{field_sw: 1'h1, host_sw: 1'h0};
      lsss_pkg::LSSS_SRC_HOST:  r = '{field_sw: 1'h0, host_sw: 1'h1};
      lsss_pkg::LSSS_SRC_OFF:   r = '0;
      default:                  r = '0; // Unused code opens both
    endcase
    return r;
  endfunction : src_to_sw

  // Source choice; the field rail wins so the host supply is spared whenever possible
  always_comb begin
    if (fld_ok_r) begin
      src_nxt = lsss_pkg::LSSS_SRC_FIELD;
    end else if (host_req || hold_r != '0) begin
      src_nxt = lsss_pkg::LSSS_SRC_HOST;
    end else begin
      src_nxt = lsss_pkg::LSSS_SRC_OFF;
    end
  end

  // Switches and source straight from flops; one decode keeps them consistent
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sw  <= '0;
      src <= lsss_pkg::LSSS_SRC_OFF;
    end else begin
      sw  <= src_to_sw(src_nxt);
      src <= src_nxt;
    end
  end

  // Tag logic enable follows the filtered detector; hysteresis lives in the analog
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) tag_logic_en <= 1'h0;
    else       tag_logic_en <= fld_ok_r;
  end

  // Checks
  sequence s_cs_release;
    $rose(cs_n_r) && !eew_r && !fld_ok_r;
  endsequence

  a_standby_both_open: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!fld_ok_r && cs_n_r && !eew_r && hold_r == '0) |=> (sw == '0))
    else $error("switches not open in standby");

  a_field_connects: assert property (@(posedge sys_clk) disable iff (!rstn)
    fld_ok_r |=> (sw.field_sw && src == lsss_pkg::LSSS_SRC_FIELD))
    else $error("field rail not connected");

  a_never_both_closed: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(sw.field_sw && sw.host_sw))
    else $error("both switches closed");

  a_host_on_select: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!fld_ok_r && !cs_n_r) |=> sw.host_sw)
    else $error("host rail not connected on select");

  a_host_needs_nofield: assert property (@(posedge sys_clk) disable iff (!rstn)
    sw.host_sw |-> !$past(fld_ok_r))
    else $error("host rail closed with field present");

  a_hold_after_release: assert property (@(posedge sys_clk) disable iff (!rstn)
    (s_cs_release ##0 (!fld_ok_r && cs_n_r && !eew_r)[*8]) |=> sw.host_sw)
    else $error("host switch released too early");

  a_hold_load_value: assert property (@(posedge sys_clk) disable iff (!rstn)
    host_req |=> (hold_r == HOLD_LOAD))
    else $error("hold-off not restarted");

  a_write_keeps_host: assert property (@(posedge sys_clk) disable iff (!rstn)
    (eew_r && !fld_ok_r) |=> sw.host_sw)
    else $error("host rail dropped during write");

  a_logic_enable: assert property (@(posedge sys_clk) disable iff (!rstn)
    tag_logic_en == $past(fld_ok_r))
    else $error("tag logic enable mismatch");

  // Cycles since host demand last stood, counted apart from the hold-off counter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rel_cnt_r <= '0;
    end else if (host_req) begin
      rel_cnt_r <= '0;
    end else if (rel_cnt_r != HOLD_LOAD) begin
      rel_cnt_r <= rel_cnt_r + CW'(1);
    end
  end

  // Steps of release, end of write and renewed select
  sequence s_host_drop;
    $fell(sw.host_sw) && !sw.field_sw;
  endsequence

  sequence s_write_end;
    $fell(eew_r) && cs_n_r && !fld_ok_r;
  endsequence

  sequence s_select_again;
    $fell(cs_n_r) && !fld_ok_r && sw.host_sw;
  endsequence

  a_hold_min_span: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_host_drop |-> (rel_cnt_r == HOLD_LOAD))
    else $error("host switch opened before the hold-off ran out");

  a_write_end_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_write_end |=> sw.host_sw)
    else $error("host rail dropped at end of write");

  a_select_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_select_again |=> (sw.host_sw && hold_r == HOLD_LOAD))
    else $error("renewed select did not restart the hold-off");

  a_src_matches_sw: assert property (@(posedge sys_clk) disable iff (!rstn)
    ((src == lsss_pkg::LSSS_SRC_FIELD) == sw.field_sw) &&
    ((src == lsss_pkg::LSSS_SRC_HOST) == sw.host_sw))
    else $error("source code disagrees with switches");

  a_field_opens_host: assert property (@(posedge sys_clk) disable iff (!rstn)
    fld_ok_r |=> !sw.host_sw)
    else $error("host switch closed while field is good");

  a_tag_with_field: assert property (@(posedge sys_clk) disable iff (!rstn)
    tag_logic_en == sw.field_sw)
    else $error("tag logic enable without field rail");

  a_standby_src: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!fld_ok_r && !host_req && hold_r == '0) |=> (src == lsss_pkg::LSSS_SRC_OFF))
    else $error("source not off in standby");

endmodule : lsss_selector
